// *** design/hrs_consts.vh ***
// Constants for the heat recovery sequencer: offsets, fields, reset values and timing
`ifndef HRS_CONSTS_VH
`define HRS_CONSTS_VH

// System clock and seconds tick
`define HRS_CLK_HZ          20000000
`define HRS_TICK_S          1
`define HRS_TICK_CYCLES     (`HRS_CLK_HZ * `HRS_TICK_S)

// Sequencing times, in seconds of the tick
`define HRS_REQ_DELAY_S     8'h96
`define HRS_OVERRUN_S       8'h96
`define HRS_VALVE_MASK_S    9'h104
`define HRS_FLOW_TRIP_S     6'h3C
`define HRS_SEC_PER_MIN     6'h3C

// Temperature margins in kelvin
`define HRS_HYST_K          9'h003
`define HRS_THROTTLE_K      9'h005

// Week clock in minutes, minute 0 is Monday 00:00
`define HRS_WEEK_MIN        14'h2760
`define HRS_LEGIO_START     14'h003C

// Power signal range in percent
`define HRS_POWER_MAX       8'h64

// Register byte offsets
`define HRS_ADDR_CTRL       8'h00
`define HRS_ADDR_PEXT       8'h04
`define HRS_ADDR_SETP       8'h08
`define HRS_ADDR_TLIM       8'h0C
`define HRS_ADDR_LEGIO      8'h10
`define HRS_ADDR_PCHK       8'h14
`define HRS_ADDR_LOCK       8'h18
`define HRS_ADDR_TIME       8'h1C
`define HRS_ADDR_STAT       8'h20
`define HRS_ADDR_ALARM      8'h24

// Control register bits
`define HRS_CTRL_PRESENT    0
`define HRS_CTRL_PLATE      1
`define HRS_CTRL_OFF_BTN    2
`define HRS_CTRL_EXT_PWR    3
`define HRS_CTRL_LEGIO_EN   4
`define HRS_CTRL_PRESS_EN   5
`define HRS_CTRL_BUF_FIT    6

// Alarm bits
`define HRS_ALM_LEGIO_TO    7

// Reset values
`define HRS_RST_CTRL        7'h0A
`define HRS_RST_PEXT        8'h00
`define HRS_RST_SETP        32'h07641414
`define HRS_RST_TLIM        32'h3C32373C
`define HRS_RST_LEGIO       32'h00783732
`define HRS_RST_PCHK        32'h3C051E0A
`define HRS_RST_LOCK        16'h012C

// Bus responses
`define HRS_RESP_OKAY       2'h0
`define HRS_RESP_SLVERR     2'h2

`endif

// *** design/hrs_top.v ***
// Heat recovery sequencer: request delay, pump, hot-gas valve, monitors, legionella, heating rod
`timescale 1ns/10ps
`include "hrs_consts.vh"

module hrs_top #(
	parameter TICK_CYCLES = `HRS_TICK_CYCLES
) (
	input  wire        clk_sys_i,
	input  wire        rstn_i,
	input  wire [7:0]  axi_awaddr_i,
	input  wire        axi_awvalid_i,
	output reg         axi_awready_o,
	input  wire [31:0] axi_wdata_i,
	input  wire [3:0]  axi_wstrb_i,
	input  wire        axi_wvalid_i,
	output reg         axi_wready_o,
	output reg  [1:0]  axi_bresp_o,
	output reg         axi_bvalid_o,
	input  wire        axi_bready_i,
	input  wire [7:0]  axi_araddr_i,
	input  wire        axi_arvalid_i,
	output reg         axi_arready_o,
	output reg  [31:0] axi_rdata_o,
	output reg  [1:0]  axi_rresp_o,
	output reg         axi_rvalid_o,
	input  wire        axi_rready_i,
	input  wire        estop_ok_i,
	input  wire        bms_request_i,
	input  wire        pump_ok_i,
	input  wire        flow_ok_i,
	input  wire        valve_open_fb_i,
	input  wire        valve_closed_fb_i,
	input  wire [7:0]  t_water_in_i,
	input  wire [7:0]  t_water_out_i,
	input  wire [7:0]  t_gas_in_i,
	input  wire [7:0]  t_gas_out_i,
	input  wire [7:0]  t_buf_top_i,
	input  wire [7:0]  pressure_i,
	input  wire [5:0]  sensor_break_i,
	output reg         pump_on_o,
	output reg  [7:0]  pump_speed_o,
	output reg         valve_open_o,
	output reg         rod_relay_o,
	output reg  [7:0]  power_o,
	output reg  [13:0] alarm_o
);

	localparam [1:0]  P_OFF     = 2'h0;
	localparam [1:0]  P_RUN     = 2'h1;
	localparam [1:0]  P_OVERRUN = 2'h2;
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam [24:0] TICK_LAST = TICK_LAST_I[24:0];

	reg  [24:0] tick_cnt;
	reg         tick;
	reg  [5:0]  sync1;
	reg  [5:0]  sync2;
	reg  [6:0]  ctrl;
	reg  [7:0]  pext;
	reg  [31:0] setp;
	reg  [31:0] tlim;
	reg  [31:0] legio;
	reg  [31:0] pchk;
	reg  [15:0] lockout_s;
	reg  [13:0] week_min;
	reg  [5:0]  sec_cnt;
	reg         aw_got;
	reg         w_got;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg  [7:0]  req_cnt;
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [7:0]  ovr_cnt;
	reg  [8:0]  mask_cnt;
	reg  [5:0]  flow_cnt;
	reg         flow_trip;
	reg  [7:0]  press_cnt;
	reg         press_trip;
	reg         temp_trip;
	reg  [7:0]  heat_cnt;
	reg  [15:0] lock_cnt;
	reg         legio_act;
	reg  [15:0] legio_cnt;
	reg         legio_to;
	reg         rod_hys;

	// Pins are asynchronous to the system clock
	wire estop_s  = sync2[0];
	wire bms_s    = sync2[1];
	wire pump_ok  = sync2[2];
	wire flow_ok  = sync2[3];
	wire fb_open  = sync2[4];
	wire fb_close = sync2[5];

	wire       present    = ctrl[`HRS_CTRL_PRESENT];
	wire       plate      = ctrl[`HRS_CTRL_PLATE];
	wire       off_button = ctrl[`HRS_CTRL_OFF_BTN];
	wire       ext_power  = ctrl[`HRS_CTRL_EXT_PWR];
	wire       legio_en   = ctrl[`HRS_CTRL_LEGIO_EN];
	wire       press_en   = ctrl[`HRS_CTRL_PRESS_EN];
	wire       buf_fitted = ctrl[`HRS_CTRL_BUF_FIT];
	wire [7:0] pump_thr   = setp[7:0];
	wire [7:0] pump_min   = setp[15:8];
	wire [7:0] pump_max   = setp[23:16];
	wire [7:0] spread_sp  = setp[31:24];
	wire [7:0] max_flow   = tlim[7:0];
	wire [7:0] max_ret    = tlim[15:8];
	wire [7:0] rod_on_t   = tlim[23:16];
	wire [7:0] rod_off_t  = tlim[31:24];
	wire [7:0] legio_sp   = legio[7:0];
	wire [7:0] norm_sp    = legio[15:8];
	wire [15:0] legio_max = legio[31:16];
	wire [7:0] press_lim  = pchk[7:0];
	wire [7:0] press_dly  = pchk[15:8];
	wire [7:0] gas_spread = pchk[23:16];
	wire [7:0] heat_dly   = pchk[31:24];
	wire       req_ok     = req_cnt == `HRS_REQ_DELAY_S;
	wire       run_en     = present & plate & estop_s & req_ok & ~off_button;

	function [31:0] hrs_merge(input [31:0] old, input [31:0] nw, input [3:0] strb);
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				hrs_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// Up/down by one, clamped into lo..hi
	function [7:0] hrs_step(input [7:0] v, input up, input dn, input [7:0] lo, input [7:0] hi);
		begin
			if (up && v < hi)
				hrs_step = v + 8'h01;
			else if (dn && v > lo)
				hrs_step = v - 8'h01;
			else
				hrs_step = v;
			if (hrs_step < lo)
				hrs_step = lo;
			if (hrs_step > hi)
				hrs_step = hi;
		end
	endfunction

	function hrs_mapped(input [7:0] a);
		begin
			hrs_mapped = (a[1:0] == 2'h0) && (a <= `HRS_ADDR_ALARM);
		end
	endfunction

	function [31:0] hrs_read(input [7:0] a);
		begin
			case (a)
			`HRS_ADDR_CTRL:  hrs_read = {25'h0, ctrl};
			`HRS_ADDR_PEXT:  hrs_read = {24'h0, pext};
			`HRS_ADDR_SETP:  hrs_read = setp;
			`HRS_ADDR_TLIM:  hrs_read = tlim;
			`HRS_ADDR_LEGIO: hrs_read = legio;
			`HRS_ADDR_PCHK:  hrs_read = pchk;
			`HRS_ADDR_LOCK:  hrs_read = {16'h0, lockout_s};
			`HRS_ADDR_TIME:  hrs_read = {18'h0, week_min};
			`HRS_ADDR_STAT:  hrs_read = {8'h0, pump_speed_o, power_o, 2'h0, legio_act, run_en,
				rod_relay_o, legio_act, valve_open_o, pump_on_o};
			`HRS_ADDR_ALARM: hrs_read = {18'h0, alarm_o};
			default:         hrs_read = 32'h0;
			endcase
		end
	endfunction

	wire        wr_fire  = aw_got & w_got & ~axi_bvalid_o;
	wire [31:0] wr_val   = hrs_merge(hrs_read(aw_addr), w_data, w_strb);
	wire        alarm_clr = wr_fire && aw_addr == `HRS_ADDR_ALARM && w_strb[0] && w_data[`HRS_ALM_LEGIO_TO];
	wire        min_pulse = tick && sec_cnt == `HRS_SEC_PER_MIN - 6'h01;
	wire [13:0] next_week = (week_min == `HRS_WEEK_MIN - 14'h0001) ? 14'h0 : week_min + 14'h0001;

	wire demand = run_en && power_o >= pump_thr;
	wire [8:0] w_out9 = {1'b0, t_water_out_i};
	wire [8:0] w_in9  = {1'b0, t_water_in_i};
	wire [8:0] spread_ref = w_in9 + {1'b0, spread_sp};
	wire throttle = (w_out9 + `HRS_THROTTLE_K > {1'b0, max_flow}) ||
		(w_in9 + `HRS_THROTTLE_K > {1'b0, max_ret});
	wire [7:0] ctl_sp = (legio_act && !ext_power) ? legio_sp : norm_sp;
	wire insuff = ({1'b0, t_gas_in_i} < {1'b0, t_gas_out_i} + {1'b0, gas_spread}) ||
		!(t_water_in_i < t_gas_in_i);
	wire next_valve = (next_state == P_RUN) & pump_ok & ~flow_trip & ~press_trip & ~temp_trip;
	wire fb_match = valve_open_o ? (fb_open & ~fb_close) : (fb_close & ~fb_open);
	wire valve_alarm = (mask_cnt == `HRS_VALVE_MASK_S) & ~fb_match;
	wire rod_gate = present & bms_s & buf_fitted & ~sensor_break_i[4];

	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			tick_cnt <= 25'h0;
			tick <= 1'b0;
			sync1 <= 6'h0;
			sync2 <= 6'h0;
		end else begin
			tick <= tick_cnt == TICK_LAST;
			tick_cnt <= (tick_cnt == TICK_LAST) ? 25'h0 : tick_cnt + 25'h1;
			sync1 <= {valve_closed_fb_i, valve_open_fb_i, flow_ok_i, pump_ok_i, bms_request_i, estop_ok_i};
			sync2 <= sync1;
		end
	end

	// Register slave; one write and one read in flight
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			axi_awready_o <= 1'b1;
			axi_wready_o <= 1'b1;
			axi_bvalid_o <= 1'b0;
			axi_bresp_o <= `HRS_RESP_OKAY;
			axi_arready_o <= 1'b1;
			axi_rvalid_o <= 1'b0;
			axi_rresp_o <= `HRS_RESP_OKAY;
			axi_rdata_o <= 32'h0;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			ctrl <= `HRS_RST_CTRL;
			pext <= `HRS_RST_PEXT;
			setp <= `HRS_RST_SETP;
			tlim <= `HRS_RST_TLIM;
			legio <= `HRS_RST_LEGIO;
			pchk <= `HRS_RST_PCHK;
			lockout_s <= `HRS_RST_LOCK;
			week_min <= 14'h0;
			sec_cnt <= 6'h0;
		end else begin
			if (axi_awvalid_i && axi_awready_o) begin
				aw_addr <= axi_awaddr_i;
				aw_got <= 1'b1;
				axi_awready_o <= 1'b0;
			end
			if (axi_wvalid_i && axi_wready_o) begin
				w_data <= axi_wdata_i;
				w_strb <= axi_wstrb_i;
				w_got <= 1'b1;
				axi_wready_o <= 1'b0;
			end
			if (tick) begin
				sec_cnt <= min_pulse ? 6'h0 : sec_cnt + 6'h01;
				if (min_pulse)
					week_min <= next_week;
			end
			if (wr_fire) begin
				axi_bvalid_o <= 1'b1;
				axi_bresp_o <= hrs_mapped(aw_addr) ? `HRS_RESP_OKAY : `HRS_RESP_SLVERR;
				case (aw_addr)
				`HRS_ADDR_CTRL:  ctrl <= wr_val[6:0];
				`HRS_ADDR_PEXT:  pext <= wr_val[7:0];
				`HRS_ADDR_SETP:  setp <= wr_val;
				`HRS_ADDR_TLIM:  tlim <= wr_val;
				`HRS_ADDR_LEGIO: legio <= wr_val;
				`HRS_ADDR_PCHK:  pchk <= wr_val;
				`HRS_ADDR_LOCK:  lockout_s <= wr_val[15:0];
				`HRS_ADDR_TIME: begin
					week_min <= (wr_val[13:0] < `HRS_WEEK_MIN) ? wr_val[13:0] : 14'h0;
					sec_cnt <= 6'h0;
				end
				default: ;
				endcase
			end
			if (axi_bvalid_o && axi_bready_i) begin
				axi_bvalid_o <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				axi_awready_o <= 1'b1;
				axi_wready_o <= 1'b1;
			end
			if (axi_arvalid_i && axi_arready_o) begin
				axi_arready_o <= 1'b0;
				axi_rvalid_o <= 1'b1;
				axi_rdata_o <= hrs_read(axi_araddr_i);
				axi_rresp_o <= hrs_mapped(axi_araddr_i) ? `HRS_RESP_OKAY : `HRS_RESP_SLVERR;
			end else if (axi_rvalid_o && axi_rready_i) begin
				axi_rvalid_o <= 1'b0;
				axi_arready_o <= 1'b1;
			end
		end
	end

	always @* begin
		next_state = state;
		case (state)
		P_OFF:
			if (demand)
				next_state = P_RUN;
		P_RUN:
			if (!estop_s)
				next_state = P_OFF;
			else if (!demand)
				next_state = P_OVERRUN;
		P_OVERRUN:
			if (!estop_s)
				next_state = P_OFF;
			else if (demand)
				next_state = P_RUN;
			else if (tick && ovr_cnt == `HRS_OVERRUN_S - 8'h01)
				next_state = P_OFF;
		default:
			next_state = P_OFF;
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state <= P_OFF;
			ovr_cnt <= 8'h0;
			req_cnt <= 8'h0;
			pump_on_o <= 1'b0;
			pump_speed_o <= 8'h0;
			valve_open_o <= 1'b0;
			power_o <= 8'h0;
			mask_cnt <= 9'h0;
		end else begin
			state <= next_state;
			pump_on_o <= next_state != P_OFF;
			valve_open_o <= next_valve;
			if (!bms_s)
				req_cnt <= 8'h0;
			else if (tick && !req_ok)
				req_cnt <= req_cnt + 8'h01;
			if (next_state != P_OVERRUN)
				ovr_cnt <= 8'h0;
			else if (tick)
				ovr_cnt <= ovr_cnt + 8'h01;
			if (next_state == P_OFF)
				pump_speed_o <= 8'h0;
			else if (state == P_OFF)
				pump_speed_o <= pump_min;
			else if (tick)
				pump_speed_o <= hrs_step(pump_speed_o, w_out9 > spread_ref, w_out9 < spread_ref,
					pump_min, pump_max);
			if (next_valve != valve_open_o)
				mask_cnt <= 9'h0;
			else if (tick && mask_cnt != `HRS_VALVE_MASK_S)
				mask_cnt <= mask_cnt + 9'h001;
			if (!run_en || lock_cnt != 16'h0)
				power_o <= 8'h0;
			else if (ext_power)
				power_o <= (pext > `HRS_POWER_MAX) ? `HRS_POWER_MAX : pext;
			else if (tick)
				power_o <= hrs_step(power_o, !throttle && t_water_out_i < ctl_sp,
					throttle || t_water_out_i > ctl_sp, 8'h00, `HRS_POWER_MAX);
		end
	end

	// Monitors, lockout, legionella and rod
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			flow_cnt <= 6'h0;
			flow_trip <= 1'b0;
			press_cnt <= 8'h0;
			press_trip <= 1'b0;
			temp_trip <= 1'b0;
			heat_cnt <= 8'h0;
			lock_cnt <= 16'h0;
			legio_act <= 1'b0;
			legio_cnt <= 16'h0;
			legio_to <= 1'b0;
			rod_hys <= 1'b0;
			rod_relay_o <= 1'b0;
			alarm_o <= 14'h0;
		end else begin
			if (flow_ok) begin
				flow_cnt <= 6'h0;
				flow_trip <= 1'b0;
			end else if (tick) begin
				if (flow_cnt == `HRS_FLOW_TRIP_S - 6'h01)
					flow_trip <= 1'b1;
				else
					flow_cnt <= flow_cnt + 6'h01;
			end
			if (!press_en || pressure_i >= press_lim) begin
				press_cnt <= 8'h0;
				press_trip <= 1'b0;
			end else if (tick) begin
				if (press_cnt >= press_dly)
					press_trip <= 1'b1;
				else
					press_cnt <= press_cnt + 8'h01;
			end
			if (t_water_out_i > max_flow || t_water_in_i > max_ret)
				temp_trip <= 1'b1;
			else if (w_out9 + `HRS_HYST_K <= {1'b0, max_flow} && w_in9 + `HRS_HYST_K <= {1'b0, max_ret})
				temp_trip <= 1'b0;
			if (tick) begin
				if (lock_cnt != 16'h0) begin
					lock_cnt <= lock_cnt - 16'h0001;
				end else if (valve_open_o && insuff) begin
					if (heat_cnt >= heat_dly) begin
						lock_cnt <= lockout_s;
						heat_cnt <= 8'h0;
					end else begin
						heat_cnt <= heat_cnt + 8'h01;
					end
				end else begin
					heat_cnt <= 8'h0;
				end
			end
			if (!legio_en || !present) begin
				legio_act <= 1'b0;
			end else if (!legio_act) begin
				if (min_pulse && next_week == `HRS_LEGIO_START) begin
					legio_act <= 1'b1;
					legio_cnt <= 16'h0;
				end
			end else if (t_buf_top_i >= legio_sp) begin
				legio_act <= 1'b0;
			end else if (min_pulse) begin
				legio_cnt <= legio_cnt + 16'h0001;
				if (legio_cnt + 16'h0001 >= legio_max)
					legio_act <= 1'b0;
			end
			// Set wins over software clear
			if (legio_act && legio_en && present && min_pulse && t_buf_top_i < legio_sp &&
				legio_cnt + 16'h0001 >= legio_max)
				legio_to <= 1'b1;
			else if (alarm_clr)
				legio_to <= 1'b0;
			if (t_buf_top_i < rod_on_t)
				rod_hys <= 1'b1;
			else if (t_buf_top_i > rod_off_t)
				rod_hys <= 1'b0;
			rod_relay_o <= rod_gate & (rod_hys | legio_act);
			// Missing inputs on an enabled circuit read as faults
			alarm_o <= {sensor_break_i, legio_to, lock_cnt != 16'h0, temp_trip, press_trip, flow_trip,
				valve_alarm, ~pump_ok, ~estop_s} & {14{present}};
		end
	end

endmodule

// *** testbench/heat_recovery_sequencer_tb.sv ***
// Self-checking bench of the heat recovery sequencer
`timescale 1ns/10ps
module heat_recovery_sequencer_tb;
	localparam int TICK = 4;
	localparam int PUMP = 0, VALVE = 1, ROD = 2, ALM = 3;
	logic        clk_sys_i, rstn_i, axi_awvalid_i, axi_wvalid_i, axi_bready_i, axi_arvalid_i, axi_rready_i;
	logic        estop_ok_i, bms_request_i, pump_ok_i, flow_ok_i, stuck, valve_open_fb_i, valve_closed_fb_i;
	logic        axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
	logic        pump_on_o, valve_open_o, rod_relay_o;
	logic [1:0]  axi_bresp_o, axi_rresp_o, resp;
	logic [3:0]  axi_wstrb_i;
	logic [5:0]  sensor_break_i;
	logic [7:0]  axi_awaddr_i, axi_araddr_i, t_water_in_i, t_water_out_i, t_gas_in_i, t_gas_out_i;
	logic [7:0]  t_buf_top_i, pressure_i, pump_speed_o, power_o;
	logic [13:0] alarm_o;
	logic [31:0] axi_wdata_i, axi_rdata_o, rd;
	int          mismatches, compares;
	logic [7:0]  reg_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0] reg_rst [7] = '{32'h0A, 32'h00, 32'h07641414, 32'h3C32373C, 32'h00783732, 32'h3C051E0A, 32'h012C};
	hrs_top #(.TICK_CYCLES(TICK)) uut (
		.clk_sys_i, .rstn_i, .axi_awaddr_i, .axi_awvalid_i, .axi_awready_o, .axi_wdata_i, .axi_wstrb_i,
		.axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i, .axi_araddr_i,
		.axi_arvalid_i, .axi_arready_o, .axi_rdata_o, .axi_rresp_o, .axi_rvalid_o, .axi_rready_i,
		.estop_ok_i, .bms_request_i, .pump_ok_i, .flow_ok_i, .valve_open_fb_i, .valve_closed_fb_i,
		.t_water_in_i, .t_water_out_i, .t_gas_in_i, .t_gas_out_i, .t_buf_top_i, .pressure_i,
		.sensor_break_i, .pump_on_o, .pump_speed_o, .valve_open_o, .rod_relay_o, .power_o, .alarm_o
	);
	hrs_valve_model #(.TRAVEL(20)) u_valve (
		.clk_i(clk_sys_i), .rstn_i, .cmd_i(valve_open_o), .stuck_i(stuck),
		.open_fb_o(valve_open_fb_i), .closed_fb_o(valve_closed_fb_i)
	);
	always #25 clk_sys_i = ~clk_sys_i;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic timeout;
		mismatches++;
		tally_and_finish();
	endtask
	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge clk_sys_i);
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_sys_i);
		axi_awaddr_i <= a;
		axi_wdata_i <= d;
		axi_wstrb_i <= s;
		axi_awvalid_i <= 1'b1;
		axi_wvalid_i <= 1'b1;
		axi_bready_i <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (axi_awready_o === 1'b1) axi_awvalid_i <= 1'b0;
			if (axi_wready_o === 1'b1) axi_wvalid_i <= 1'b0;
			if (axi_bvalid_o === 1'b1) break;
		end
		if (n == 50) timeout();
		resp = axi_bresp_o;
		axi_bready_i <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a);
		int n;
		@(posedge clk_sys_i);
		axi_araddr_i <= a;
		axi_arvalid_i <= 1'b1;
		axi_rready_i <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (axi_arready_o === 1'b1) axi_arvalid_i <= 1'b0;
			if (axi_rvalid_o === 1'b1) break;
		end
		if (n == 50) timeout();
		rd = axi_rdata_o;
		resp = axi_rresp_o;
		axi_rready_i <= 1'b0;
	endtask
	function automatic logic pick(input int s);
		case (s)
			PUMP: return pump_on_o;
			VALVE: return valve_open_o;
			ROD: return rod_relay_o;
			default: return alarm_o[s - ALM];
		endcase
	endfunction
	// Bounded wait on one output, judged as soon as it matches or when the bound runs out
	task automatic await(input int s, input logic v, input int t);
		int n;
		for (n = 0; n < t * TICK && pick(s) !== v; n++) @(posedge clk_sys_i);
		check(pick(s), v);
	endtask
	task automatic s_registers;
		int i;
		for (i = 0; i < 7; i++) begin
			axi_read(reg_addr[i]);
			check(rd, reg_rst[i]);
		end
		axi_write(8'h08, 32'hFFFFFF15, 4'h1);
		axi_read(8'h08);
		check(rd, 32'h07641415);
		axi_write(8'h08, 32'h00000014, 4'h1);
		axi_write(8'h20, 32'hFFFFFFFF, 4'hF);
		check(resp, 2'h0);
		axi_write(8'h28, 32'h00000001, 4'hF);
		check(resp, 2'h2);
		axi_read(8'h02);
		check(resp, 2'h2);
		check(pump_on_o | valve_open_o | rod_relay_o, 1'b0);
	endtask
	task automatic s_start;
		axi_write(8'h00, 32'h07, 4'hF);
		bms_request_i <= 1'b1;
		ticks(160);
		check(power_o, 8'h00);
		check(pump_on_o, 1'b0);
		axi_write(8'h00, 32'h03, 4'hF);
		await(PUMP, 1'b1, 200);
		check(power_o >= 8'h14, 1'b1);
		check(valve_open_o, 1'b1);
		check(pump_speed_o, 8'h14);
		ticks(90);
		check(pump_speed_o, 8'h64);
		t_water_in_i <= 8'h25;
		ticks(90);
		check(pump_speed_o, 8'h14);
	endtask
	task automatic s_fault_and_mask;
		pump_ok_i <= 1'b0;
		await(VALVE, 1'b0, 2);
		await(ALM + 1, 1'b1, 2);
		check(pump_on_o, 1'b1);
		stuck <= 1'b1;
		pump_ok_i <= 1'b1;
		await(VALVE, 1'b1, 2);
		ticks(250);
		check(alarm_o[2], 1'b0);
		await(ALM + 2, 1'b1, 20);
		stuck <= 1'b0;
	endtask
	task automatic s_trips;
		flow_ok_i <= 1'b0;
		ticks(55);
		check(valve_open_o, 1'b1);
		await(VALVE, 1'b0, 10);
		await(ALM + 3, 1'b1, 1);
		check(pump_on_o, 1'b1);
		flow_ok_i <= 1'b1;
		await(VALVE, 1'b1, 2);
		t_water_out_i <= 8'h3D;
		await(VALVE, 1'b0, 2);
		await(ALM + 5, 1'b1, 2);
		t_water_out_i <= 8'h3A;
		ticks(4);
		check(valve_open_o, 1'b0);
		t_water_out_i <= 8'h39;
		await(VALVE, 1'b1, 4);
		t_water_out_i <= 8'h28;
	endtask
	task automatic s_press_and_lock;
		axi_write(8'h00, 32'h23, 4'hF);
		pressure_i <= 8'h05;
		ticks(25);
		check(valve_open_o, 1'b1);
		await(VALVE, 1'b0, 10);
		await(ALM + 4, 1'b1, 1);
		check(pump_on_o, 1'b1);
		pressure_i <= 8'h64;
		await(VALVE, 1'b1, 2);
		axi_write(8'h18, 32'h0000000A, 4'hF);
		t_gas_in_i <= 8'h1A;
		ticks(55);
		check(alarm_o[6], 1'b0);
		await(ALM + 6, 1'b1, 10);
		check(power_o, 8'h00);
		t_gas_in_i <= 8'h50;
		ticks(5);
		check(power_o, 8'h00);
		check(pump_on_o, 1'b1);
		await(ALM + 6, 1'b0, 10);
		await(VALVE, 1'b1, 30);
		axi_write(8'h04, 32'h00000078, 4'hF);
		axi_write(8'h00, 32'h0B, 4'hF);
		ticks(1);
		check(power_o, 8'h64);
		axi_write(8'h00, 32'h03, 4'hF);
	endtask
	task automatic s_rod_and_legionella;
		axi_write(8'h00, 32'h43, 4'hF);
		t_buf_top_i <= 8'h2D;
		await(ROD, 1'b1, 2);
		t_buf_top_i <= 8'h37;
		ticks(2);
		check(rod_relay_o, 1'b1);
		t_buf_top_i <= 8'h3E;
		await(ROD, 1'b0, 2);
		t_buf_top_i <= 8'h2D;
		await(ROD, 1'b1, 2);
		sensor_break_i <= 6'h10;
		await(ROD, 1'b0, 1);
		await(ALM + 12, 1'b1, 1);
		sensor_break_i <= 6'h00;
		t_buf_top_i <= 8'h3E;
		axi_write(8'h10, 32'h00013746, 4'hF);
		axi_write(8'h00, 32'h53, 4'hF);
		axi_write(8'h1C, 32'h0000003B, 4'hF);
		ticks(55);
		check(rod_relay_o, 1'b0);
		await(ROD, 1'b1, 10);
		axi_read(8'h20);
		check(rd[3], 1'b1);
		await(ALM + 7, 1'b1, 70);
		check(rod_relay_o, 1'b0);
		axi_write(8'h24, 32'h00000080, 4'hF);
		axi_read(8'h24);
		check(rd[7], 1'b0);
	endtask
	task automatic s_stop_and_alarms;
		bms_request_i <= 1'b0;
		await(VALVE, 1'b0, 2);
		ticks(145);
		check(pump_on_o, 1'b1);
		await(PUMP, 1'b0, 10);
		bms_request_i <= 1'b1;
		ticks(145);
		check(pump_on_o, 1'b0);
		await(PUMP, 1'b1, 200);
		estop_ok_i <= 1'b0;
		await(PUMP, 1'b0, 1);
		check(valve_open_o, 1'b0);
		await(ALM, 1'b1, 1);
		estop_ok_i <= 1'b1;
		sensor_break_i <= 6'h2A;
		ticks(1);
		check(alarm_o[13:8], 6'h2A);
		axi_write(8'h00, 32'h42, 4'hF);
		ticks(1);
		check(alarm_o, 14'h0000);
	endtask
	initial begin
		clk_sys_i = 1'b0;
		rstn_i = 1'b0;
		{axi_awvalid_i, axi_wvalid_i, axi_bready_i, axi_arvalid_i, axi_rready_i, bms_request_i, stuck} = 7'h00;
		{estop_ok_i, pump_ok_i, flow_ok_i} = 3'h7;
		{axi_awaddr_i, axi_araddr_i, axi_wstrb_i, axi_wdata_i, sensor_break_i} = 58'h0;
		{t_water_in_i, t_water_out_i, t_gas_in_i, t_gas_out_i} = 32'h1E285032;
		{t_buf_top_i, pressure_i} = 16'h3764;
		mismatches = 0;
		compares = 0;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		s_registers();
		s_start();
		s_fault_and_mask();
		s_trips();
		s_press_and_lock();
		s_rod_and_legionella();
		s_stop_and_alarms();
		tally_and_finish();
	end
endmodule
bind hrs_top hrs_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clk_sys_i, .rstn_i, .estop_ok_i, .bms_request_i, .pump_ok_i, .sensor_break_i,
	.pump_on_o, .pump_speed_o, .valve_open_o, .rod_relay_o, .power_o, .alarm_o
);

// *** testbench/hrs_top_monitor.sv ***
// Port checker of the heat recovery sequencer
`timescale 1ns/10ps
module hrs_top_monitor #(
	parameter TICK_CYCLES = 4
) (
	input wire        clk_sys_i,
	input wire        rstn_i,
	input wire        estop_ok_i,
	input wire        bms_request_i,
	input wire        pump_ok_i,
	input wire [5:0]  sensor_break_i,
	input wire        pump_on_o,
	input wire [7:0]  pump_speed_o,
	input wire        valve_open_o,
	input wire        rod_relay_o,
	input wire [7:0]  power_o,
	input wire [13:0] alarm_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	// Pins pass a two-stage sync, so four low samples cover the response
	property p_estop_off;
		(!estop_ok_i) [*4] |-> !pump_on_o && !valve_open_o;
	endproperty
	a_estop_off: assert property (p_estop_off) else $error("pump or valve on in estop");
	property p_valve_pump;
		valve_open_o |-> pump_on_o;
	endproperty
	a_valve_pump: assert property (p_valve_pump) else $error("valve open without pump");
	property p_fault_valve;
		(!pump_ok_i) [*4] |-> !valve_open_o;
	endproperty
	a_fault_valve: assert property (p_fault_valve) else $error("valve open with pump fault");
	property p_demand_valve;
		(!bms_request_i) [*5] |-> !valve_open_o;
	endproperty
	a_demand_valve: assert property (p_demand_valve) else $error("valve open without demand");
	property p_speed_off;
		!pump_on_o |-> pump_speed_o == 8'h00;
	endproperty
	a_speed_off: assert property (p_speed_off) else $error("speed while pump off");
	property p_speed_step;
		pump_on_o && $past(pump_on_o) |-> pump_speed_o == $past(pump_speed_o)
			|| pump_speed_o == $past(pump_speed_o) + 8'h01 || pump_speed_o == $past(pump_speed_o) - 8'h01;
	endproperty
	a_speed_step: assert property (p_speed_step) else $error("speed jumped");
	property p_power_max;
		power_o <= 8'h64;
	endproperty
	a_power_max: assert property (p_power_max) else $error("power above range");
	property p_break_cause;
		(alarm_o[13:8] & ~($past(sensor_break_i) | $past(sensor_break_i, 2))) == 6'h00;
	endproperty
	a_break_cause: assert property (p_break_cause) else $error("break alarm without break");
	property p_rod_request;
		(!bms_request_i) [*4] |-> !rod_relay_o;
	endproperty
	a_rod_request: assert property (p_rod_request) else $error("rod on without request");
	property p_reset_off;
		$rose(rstn_i) |-> !pump_on_o && !valve_open_o && !rod_relay_o && power_o == 8'h00 && alarm_o == 14'h0000;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("outputs active out of reset");
	c_pump: cover property ($rose(pump_on_o));
	c_rod: cover property ($rose(rod_relay_o));
	c_flow: cover property ($rose(alarm_o[3]));
	c_mask: cover property ($rose(alarm_o[2]));
endmodule

// *** testbench/hrs_valve_model.sv ***
// Hot-gas valve actuator with end position switches
`timescale 1ns/10ps
module hrs_valve_model #(
	parameter int TRAVEL = 20
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic cmd_i,
	input  wire logic stuck_i,
	output logic      open_fb_o,
	output logic      closed_fb_o
);
	int   cnt;
	logic pos;
	always @(posedge clk_i) begin
		if (!rstn_i || pos == cmd_i) begin
			cnt <= 0;
			if (!rstn_i) pos <= 1'b0;
		end else if (cnt == TRAVEL) begin
			pos <= cmd_i;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Both switches low in travel; a stuck actuator keeps reporting closed
	assign open_fb_o   = !stuck_i && pos && pos == cmd_i;
	assign closed_fb_o = stuck_i || (!pos && pos == cmd_i);
endmodule
